// File: core/gdi_pkg.sv
/*
  constants, carrier types and state encodings for the general device interface.
  assumes a 25 MHz hclk and an AHB-Lite master that issues aligned single word transfers.
*/
package gdi_pkg;

  // ==========================================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned PULSE_NS = 2000;
  // a pulse of roughly the printed width: whole cycles, never less than one
  localparam int unsigned PULSE_CYC = (PULSE_NS / CLK_PERIOD_NS) > 0 ?
                                      (PULSE_NS / CLK_PERIOD_NS) : 1;
  localparam int PULSE_W = 6;
  localparam logic [PULSE_W-1:0] PULSE_CNT = PULSE_W'(PULSE_CYC);
  localparam logic [PULSE_W-1:0] PULSE_ZERO = 6'h00;

  // ==========================================================================
  // register offsets (byte addresses)
  localparam logic [7:0] CSR_OFS = 8'h00;
  localparam logic [7:0] BUF_OFS = 8'h04;
  localparam logic [7:0] INP_OFS = 8'h08;
  localparam logic [7:0] CFG_OFS = 8'h0C;

  // control and status fields
  localparam int CSR_ENA_A_BIT = 6;
  localparam int CSR_ENA_B_BIT = 5;
  localparam int CSR_FLAG_A_BIT = 7;
  localparam int CSR_FLAG_B_BIT = 15;

  // configuration fields: fitted vector jumpers and request level
  localparam int CFG_JMP_LSB = 0;
  localparam int CFG_JMP_W = 6;
  localparam int CFG_LVL_LSB = 8;
  localparam int CFG_LVL_W = 2;
  localparam logic [CFG_JMP_W-1:0] JMP_RST = 6'h00;
  localparam logic [CFG_LVL_W-1:0] LVL_RST = 2'h1;

  // vector field on the bus data lines
  localparam int VEC_HI = 8;
  localparam int VEC_LO = 3;
  localparam int VEC_SEL_BIT = 2;
  localparam logic [15:0] VEC_OE = 16'h01FF;

  localparam logic [15:0] BUF_RST = 16'h0000;
  localparam logic [31:0] WORD_ZERO = 32'h00000000;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic flag;
    logic release_req;
    logic vector_start;
  } gdi_user_in_t;

  typedef struct packed {
    logic owner;
    logic vector_done;
  } gdi_user_out_t;

  typedef struct packed {
    logic bus_grant;
    logic bus_busy;
    logic slave_sync;
  } gdi_bus_in_t;

  typedef struct packed {
    logic [3:0] bus_request_line;
    logic bus_grant_out;
    logic selection_acknowledge_o;
    logic selection_acknowledge_oe;
    logic bus_busy_o;
    logic bus_busy_oe;
    logic interrupt_vector_strobe_o;
    logic interrupt_vector_strobe_oe;
    logic [15:0] data_o;
    logic [15:0] data_oe;
  } gdi_bus_out_t;

  // ==========================================================================
  // states
  typedef enum logic [2:0] {MC_IDLE, MC_REQ, MC_ACK, MC_OWN, MC_DONE} gdi_mc_state_t;
  typedef enum logic [1:0] {VS_IDLE, VS_DRIVE, VS_DONE} gdi_vec_state_t;

endpackage : gdi_pkg

// File: core/gdi_top.sv
/*
  general device interface: AHB-Lite register slave, 16-bit output buffer,
  16-bit input port, two flag/request channels with master control and a
  vectored interrupt handshake on the system bus side.
  assumes all pin inputs are asynchronous to hclk; open-drain bus lines are
  resolved outside from the output enables.
*/
// Our own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
module gdi_top
(
  // ==========================================================================
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ==========================================================================
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // ==========================================================================
  // system bus side
  input wire gdi_pkg::gdi_bus_in_t bus_in,
  output gdi_pkg::gdi_bus_out_t bus_out,
  // ==========================================================================
  // peripheral side
  input wire gdi_pkg::gdi_user_in_t [1:0] user_in,
  input wire logic vector_low_select,
  input wire logic [15:0] input_lines,
  output gdi_pkg::gdi_user_out_t [1:0] user_out,
  output logic [15:0] buffer_out,
  output logic output_loaded,
  output logic input_read
);

  // ==========================================================================
  // input synchronisers
  logic [2:0] bus_meta_ff;
  logic [2:0] bus_sync_ff;
  logic [5:0] usr_meta_ff;
  logic [5:0] usr_sync_ff;
  logic [16:0] dat_meta_ff;
  logic [16:0] dat_sync_ff;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus_meta_ff <= 3'h0;
      bus_sync_ff <= 3'h0;
      usr_meta_ff <= 6'h00;
      usr_sync_ff <= 6'h00;
      dat_meta_ff <= 17'h00000;
      dat_sync_ff <= 17'h00000;
    end
    else
    begin
      bus_meta_ff <= bus_in;
      bus_sync_ff <= bus_meta_ff;
      usr_meta_ff <= user_in;
      usr_sync_ff <= usr_meta_ff;
      dat_meta_ff <= {vector_low_select, input_lines};
      dat_sync_ff <= dat_meta_ff;
    end
  end

  gdi_pkg::gdi_bus_in_t bus_s;
  gdi_pkg::gdi_user_in_t [1:0] usr_s;
  logic vec_low_s;
  logic [15:0] inputs_s;

  assign bus_s = bus_sync_ff;
  assign usr_s = usr_sync_ff;
  assign vec_low_s = dat_sync_ff[16];
  assign inputs_s = dat_sync_ff[15:0];

  // ==========================================================================
  // AHB-Lite address and data phase
  function automatic logic word_ok(input logic [31:0] addr, input logic [2:0] size);
    word_ok = (addr[1:0] == 2'h0) && (size == 3'h2);
  endfunction : word_ok

  logic accept;
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [31:0] hrdata_ff;
  logic rd_inp;

  assign accept = hsel && htrans[1] && hready;
  // a read of the input register is acted on in its address phase
  assign rd_inp = accept && !hwrite && word_ok(haddr, hsize) && (haddr[7:0] == gdi_pkg::INP_OFS);

  // zero wait states: read data are captured at the address phase edge
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end
    else if (hready)
    begin
      wr_pend_ff <= accept && hwrite && word_ok(haddr, hsize) && (haddr[31:8] == 24'h000000);
      wr_addr_ff <= haddr[7:0];
    end
  end

  // ==========================================================================
  // registers
  logic [1:0] enable_ff;
  logic [15:0] buf_ff;
  logic [gdi_pkg::CFG_JMP_W-1:0] jumper_ff;
  logic [gdi_pkg::CFG_LVL_W-1:0] level_ff;
  logic wr_csr;
  logic wr_buf;
  logic wr_cfg;

  assign wr_csr = wr_pend_ff && (wr_addr_ff == gdi_pkg::CSR_OFS);
  assign wr_buf = wr_pend_ff && (wr_addr_ff == gdi_pkg::BUF_OFS);
  assign wr_cfg = wr_pend_ff && (wr_addr_ff == gdi_pkg::CFG_OFS);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      enable_ff <= 2'h0;
    else if (wr_csr)
    begin
      enable_ff[0] <= hwdata[gdi_pkg::CSR_ENA_A_BIT];
      enable_ff[1] <= hwdata[gdi_pkg::CSR_ENA_B_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      buf_ff <= gdi_pkg::BUF_RST;
    else if (wr_buf)
      buf_ff <= hwdata[15:0];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      jumper_ff <= gdi_pkg::JMP_RST;
      level_ff <= gdi_pkg::LVL_RST;
    end
    else if (wr_cfg)
    begin
      jumper_ff <= hwdata[gdi_pkg::CFG_JMP_LSB +: gdi_pkg::CFG_JMP_W];
      level_ff <= hwdata[gdi_pkg::CFG_LVL_LSB +: gdi_pkg::CFG_LVL_W];
    end
  end

  assign buffer_out = buf_ff;

  // read mux: flags show the live lines whatever the enables say
  logic [31:0] rd_word;

  always_comb
  begin
    rd_word = gdi_pkg::WORD_ZERO;
    if (word_ok(haddr, hsize) && (haddr[31:8] == 24'h000000))
    begin
      unique case (haddr[7:0])
        gdi_pkg::CSR_OFS:
        begin
          rd_word[gdi_pkg::CSR_ENA_A_BIT] = enable_ff[0];
          rd_word[gdi_pkg::CSR_ENA_B_BIT] = enable_ff[1];
          rd_word[gdi_pkg::CSR_FLAG_A_BIT] = usr_s[0].flag;
          rd_word[gdi_pkg::CSR_FLAG_B_BIT] = usr_s[1].flag;
        end
        gdi_pkg::BUF_OFS: rd_word[15:0] = buf_ff;
        gdi_pkg::INP_OFS: rd_word[15:0] = inputs_s;
        gdi_pkg::CFG_OFS:
        begin
          rd_word[gdi_pkg::CFG_JMP_LSB +: gdi_pkg::CFG_JMP_W] = jumper_ff;
          rd_word[gdi_pkg::CFG_LVL_LSB +: gdi_pkg::CFG_LVL_W] = level_ff;
        end
        default: rd_word = gdi_pkg::WORD_ZERO;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_ff <= gdi_pkg::WORD_ZERO;
    else if (accept && !hwrite)
      hrdata_ff <= rd_word;
  end

  // ==========================================================================
  // peripheral pulses
  logic [gdi_pkg::PULSE_W-1:0] load_cnt_ff;
  logic [gdi_pkg::PULSE_W-1:0] read_cnt_ff;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      load_cnt_ff <= gdi_pkg::PULSE_ZERO;
    else if (wr_buf)
      load_cnt_ff <= gdi_pkg::PULSE_CNT;
    else if (load_cnt_ff != gdi_pkg::PULSE_ZERO)
      load_cnt_ff <= load_cnt_ff - 6'h01;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      read_cnt_ff <= gdi_pkg::PULSE_ZERO;
    else if (rd_inp)
      read_cnt_ff <= gdi_pkg::PULSE_CNT;
    else if (read_cnt_ff != gdi_pkg::PULSE_ZERO)
      read_cnt_ff <= read_cnt_ff - 6'h01;
  end

  // a new access restarts the pulse rather than stretching a second one
  assign output_loaded = load_cnt_ff != gdi_pkg::PULSE_ZERO;
  assign input_read = read_cnt_ff != gdi_pkg::PULSE_ZERO;

  // ==========================================================================
  // master control, one machine per channel
  gdi_pkg::gdi_mc_state_t [1:0] mc_state_ff;
  gdi_pkg::gdi_mc_state_t [1:0] nxt_mc_state;
  logic [1:0] want;
  logic [1:0] grant_into;
  logic [1:0] grant_pass;

  // channel A sees the grant first, so it outranks channel B
  assign grant_into[0] = bus_s.bus_grant;
  assign grant_into[1] = grant_pass[0];

  always_comb
  begin
    for (int ch = 0; ch < 2; ch++)
    begin
      want[ch] = usr_s[ch].flag && enable_ff[ch];
      grant_pass[ch] = grant_into[ch] && ((mc_state_ff[ch] == gdi_pkg::MC_IDLE) ||
                       (mc_state_ff[ch] == gdi_pkg::MC_OWN) ||
                       (mc_state_ff[ch] == gdi_pkg::MC_DONE));
      nxt_mc_state[ch] = mc_state_ff[ch];
      unique case (mc_state_ff[ch])
        gdi_pkg::MC_IDLE:
          if (want[ch])
            nxt_mc_state[ch] = gdi_pkg::MC_REQ;
        gdi_pkg::MC_REQ:
          if (!want[ch])
            nxt_mc_state[ch] = gdi_pkg::MC_IDLE;
          else if (grant_into[ch])
            nxt_mc_state[ch] = gdi_pkg::MC_ACK;
        gdi_pkg::MC_ACK:
          if (!grant_into[ch] && !bus_s.bus_busy && !bus_s.slave_sync)
            nxt_mc_state[ch] = gdi_pkg::MC_OWN;
        gdi_pkg::MC_OWN:
          if (usr_s[ch].release_req)
            nxt_mc_state[ch] = gdi_pkg::MC_DONE;
          else if (!want[ch])
            nxt_mc_state[ch] = gdi_pkg::MC_IDLE;
        gdi_pkg::MC_DONE:
          if (!want[ch])
            nxt_mc_state[ch] = gdi_pkg::MC_IDLE;
        default: nxt_mc_state[ch] = gdi_pkg::MC_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mc_state_ff[0] <= gdi_pkg::MC_IDLE;
      mc_state_ff[1] <= gdi_pkg::MC_IDLE;
    end
    else
      mc_state_ff <= nxt_mc_state;
  end

  // ==========================================================================
  // vector transfer
  gdi_pkg::gdi_vec_state_t vec_state_ff;
  logic vec_chan_ff;
  logic [1:0] done_ff;
  logic [15:0] vec_data_ff;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      vec_state_ff <= gdi_pkg::VS_IDLE;
      vec_chan_ff <= 1'b0;
      done_ff <= 2'h0;
      vec_data_ff <= 16'h0000;
    end
    else
    begin
      unique case (vec_state_ff)
        gdi_pkg::VS_IDLE:
          if (usr_s[0].vector_start || usr_s[1].vector_start)
          begin
            vec_state_ff <= gdi_pkg::VS_DRIVE;
            vec_chan_ff <= !usr_s[0].vector_start;
            vec_data_ff <= 16'h0000;
            vec_data_ff[gdi_pkg::VEC_HI:gdi_pkg::VEC_LO] <= ~jumper_ff;
            vec_data_ff[gdi_pkg::VEC_SEL_BIT] <= vec_low_s;
          end
        gdi_pkg::VS_DRIVE:
          if (bus_s.slave_sync)
          begin
            vec_state_ff <= gdi_pkg::VS_DONE;
            done_ff[vec_chan_ff] <= 1'b1;
          end
        gdi_pkg::VS_DONE:
          // done holds until the user drops its start, so one start gives one vector
          if (!usr_s[vec_chan_ff].vector_start)
          begin
            vec_state_ff <= gdi_pkg::VS_IDLE;
            done_ff <= 2'h0;
          end
        default: vec_state_ff <= gdi_pkg::VS_IDLE;
      endcase
    end
  end

  logic vec_drive;
  assign vec_drive = vec_state_ff == gdi_pkg::VS_DRIVE;

  // ==========================================================================
  // outputs
  logic [1:0] req_on;
  logic [1:0] ack_on;
  logic [1:0] own_on;

  always_comb
  begin
    for (int ch = 0; ch < 2; ch++)
    begin
      req_on[ch] = (mc_state_ff[ch] == gdi_pkg::MC_REQ) ||
                   (mc_state_ff[ch] == gdi_pkg::MC_ACK);
      ack_on[ch] = mc_state_ff[ch] == gdi_pkg::MC_ACK;
      own_on[ch] = mc_state_ff[ch] == gdi_pkg::MC_OWN;
      user_out[ch].owner = own_on[ch];
      user_out[ch].vector_done = done_ff[ch];
    end
  end

  always_comb
  begin
    bus_out.bus_request_line = 4'h0;
    bus_out.bus_request_line[level_ff] = |req_on;
    bus_out.bus_grant_out = grant_pass[1];
    bus_out.selection_acknowledge_o = |ack_on;
    bus_out.selection_acknowledge_oe = |ack_on;
    bus_out.bus_busy_o = |own_on;
    bus_out.bus_busy_oe = |own_on;
    bus_out.interrupt_vector_strobe_o = vec_drive;
    bus_out.interrupt_vector_strobe_oe = vec_drive;
    bus_out.data_o = vec_data_ff;
    bus_out.data_oe = vec_drive ? gdi_pkg::VEC_OE : 16'h0000;
  end

endmodule : gdi_top

// File: verif/gdi_bus_model.sv
/*
  far side model: arbiter and processor that answer the block's system bus side.
  assumes the bench picks prompt or slow answers and the busy level of other masters.
*/
`timescale 1ns/1ps
module gdi_bus_model
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // block side
  input wire gdi_pkg::gdi_bus_out_t bus_out,
  output gdi_pkg::gdi_bus_in_t bus_in,
  // bench controls
  input wire logic slow,
  input wire logic other_busy
);
  // ==========================================================================
  // answers
  logic grant_ff;
  logic sync_ff;
  logic [3:0] lag_ff;
  wire logic want = (|bus_out.bus_request_line && !bus_out.selection_acknowledge_oe)
                    || bus_out.interrupt_vector_strobe_o;
  wire logic ripe = lag_ff >= (slow ? 4'hA : 4'h1);
  // busy is open drain: other masters or the block itself pull it
  assign bus_in = '{grant_ff, other_busy || bus_out.bus_busy_oe, sync_ff};
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lag_ff <= 4'h0;
      grant_ff <= 1'b0;
      sync_ff <= 1'b0;
    end
    else
    begin
      // saturating, so a long wait never wraps and drops an answer
      lag_ff <= !want ? 4'h0 : (lag_ff == 4'hF ? lag_ff : lag_ff + 4'h1);
      // the grant enters the nearest device first and leaves on acknowledge
      grant_ff <= |bus_out.bus_request_line && !bus_out.selection_acknowledge_oe
                  && ripe;
      sync_ff <= bus_out.interrupt_vector_strobe_o && ripe;
    end
  end
endmodule : gdi_bus_model

// File: verif/gdi_checker.sv
/*
  concurrent checks on the ports of the general device interface top.
  assumes one hclk domain and the map and timing of gdi_pkg.
*/
`timescale 1ns/1ps
module gdi_checker
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  // system bus and user side
  input wire gdi_pkg::gdi_bus_in_t bus_in,
  input wire gdi_pkg::gdi_bus_out_t bus_out,
  input wire gdi_pkg::gdi_user_in_t [1:0] user_in,
  input wire gdi_pkg::gdi_user_out_t [1:0] user_out,
  input wire logic [15:0] buffer_out,
  input wire logic output_loaded,
  input wire logic input_read
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========================================================================
  // helpers
  logic wr_buf_ff;
  wire logic take = hsel && htrans[1] && hready;
  wire logic own = user_out[0].owner || user_out[1].owner;
  wire logic done = user_out[0].vector_done || user_out[1].vector_done;
  wire logic start = user_in[0].vector_start || user_in[1].vector_start;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wr_buf_ff <= 1'b0;
    else
      wr_buf_ff <= take && hwrite && haddr == {24'h000000, gdi_pkg::BUF_OFS};
  end
  sequence s_read_pulse;
    ##49 input_read ##1 !input_read;
  endsequence
  // ==========================================================================
  // assertions
  a_load_start: assert property (
    wr_buf_ff |=> output_loaded && buffer_out == $past(hwdata[15:0]))
    else $error("buffer load or its pulse missing");
  a_read_pulse: assert property (take && !hwrite && haddr == 32'h00000008 |=> input_read)
    else $error("input read pulse missing");
  a_pulse_width: assert property ($rose(input_read) |-> s_read_pulse)
    else $error("input read pulse width wrong");
  a_request_gate: assert property (
    (!user_in[0].flag && !user_in[1].flag) [*5] |-> bus_out.bus_request_line == 4'h0)
    else $error("request without flag");
  a_sack_grant: assert property (
    $rose(bus_out.selection_acknowledge_oe) |-> $past(bus_in.bus_grant, 2))
    else $error("acknowledge without grant");
  a_owner_busy: assert property (
    $rose(own) |-> bus_out.bus_busy_oe && !$past(bus_in.bus_busy, 2) &&
    bus_out.bus_request_line == 4'h0)
    else $error("owner taken wrongly");
  a_grant_block: assert property (
    bus_out.bus_request_line != 4'h0 |-> !bus_out.bus_grant_out)
    else $error("grant passed while requesting");
  a_vector_shape: assert property (
    bus_out.interrupt_vector_strobe_o |-> bus_out.data_oe == gdi_pkg::VEC_OE &&
    bus_out.data_o[1:0] == 2'h0)
    else $error("vector field shape wrong");
  a_vector_cause: assert property (
    $rose(bus_out.interrupt_vector_strobe_o) |-> $past(start, 2))
    else $error("strobe without start");
  a_done_sync: assert property (
    $rose(done) |-> !bus_out.interrupt_vector_strobe_o && $past(bus_in.slave_sync, 2))
    else $error("done without slave sync");
endmodule : gdi_checker

bind gdi_top gdi_checker u_chk
(
  .hclk(hclk),
  .hresetn(hresetn),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hwdata(hwdata),
  .hready(hready),
  .bus_in(bus_in),
  .bus_out(bus_out),
  .user_in(user_in),
  .user_out(user_out),
  .buffer_out(buffer_out),
  .output_loaded(output_loaded),
  .input_read(input_read)
);

// File: verif/tb_gdi_top.sv
/*
  self-checking bench for gdi_top with the bus model on its system bus side.
  assumes a 25 MHz hclk, a zero-wait slave and the register map of gdi_pkg.
*/
`timescale 1ns/1ps
module tb_gdi_top;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  gdi_pkg::gdi_bus_in_t bus_in;
  gdi_pkg::gdi_bus_out_t bus_out;
  gdi_pkg::gdi_user_in_t [1:0] user_in;
  gdi_pkg::gdi_user_out_t [1:0] user_out;
  logic vector_low_select;
  logic [15:0] input_lines;
  logic [15:0] buffer_out;
  logic output_loaded;
  logic input_read;
  logic slow;
  logic other_busy;
  int errors;
  int n_tests;
  // ==========================================================================
  // design and far side
  gdi_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .bus_in(bus_in),
    .bus_out(bus_out), .user_in(user_in), .vector_low_select(vector_low_select),
    .input_lines(input_lines), .user_out(user_out), .buffer_out(buffer_out),
    .output_loaded(output_loaded), .input_read(input_read));
  gdi_bus_model u_far (.hclk(hclk), .hresetn(hresetn), .bus_out(bus_out), .bus_in(bus_in),
    .slow(slow), .other_busy(other_busy));
  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // ==========================================================================
  // shared tasks
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_word
  // index: owner a/b, strobe, done a/b, acknowledge, load, read, request, ready
  function automatic logic probe(input int k);
    case (k)
      0: return user_out[0].owner;
      1: return user_out[1].owner;
      2: return bus_out.interrupt_vector_strobe_o;
      3: return user_out[0].vector_done;
      4: return user_out[1].vector_done;
      5: return bus_out.selection_acknowledge_o;
      6: return output_loaded;
      7: return input_read;
      8: return |bus_out.bus_request_line;
      default: return hreadyout;
    endcase
  endfunction : probe
  task automatic wait_for(input int k, input logic v, input int lim, output int n);
    for (n = 1; n <= lim; n++)
    begin
      @(posedge hclk);
      if (probe(k) === v)
        return;
    end
    errors++;
    $display("ERROR %0t wait on %0d ran out", $time, k);
    finish_test();
  endtask : wait_for
  // entered just after a rising edge; address phase, then data phase
  task automatic ahb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] q);
    int n;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    wait_for(9, 1'b1, 20, n);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_for(9, 1'b1, 20, n);
    q = hrdata;
    check_word({31'h0, hresp}, 32'h0, "response");
  endtask : ahb_xfer
  // ==========================================================================
  // scenarios
  task automatic t_reset();
    logic [31:0] q;
    ahb_xfer(1'b0, gdi_pkg::CSR_OFS, 32'h0, q);
    check_word(q, 32'h00000000, "status at reset");
    ahb_xfer(1'b0, gdi_pkg::BUF_OFS, 32'h0, q);
    check_word({16'h0000, buffer_out}, 32'h00000000, "buffer pins at reset");
    check_word(q, 32'h00000000, "buffer zero");
    ahb_xfer(1'b0, gdi_pkg::CFG_OFS, 32'h0, q);
    check_word(q, 32'h00000100, "level at reset");
    $display("test reset done");
  endtask : t_reset
  task automatic t_buffer();
    logic [31:0] q;
    int n;
    ahb_xfer(1'b1, gdi_pkg::BUF_OFS, 32'hDEADA5C3, q);
    wait_for(6, 1'b1, 1, n);
    check_word({16'h0000, buffer_out}, 32'h0000A5C3, "buffer out");
    wait_for(6, 1'b0, 60, n);
    check_word(32'(n), gdi_pkg::PULSE_CYC, "load pulse");
    ahb_xfer(1'b1, 8'h10, 32'h0000FFFF, q);
    ahb_xfer(1'b0, 8'h10, 32'h0, q);
    check_word(q, 32'h00000000, "unmapped read");
    ahb_xfer(1'b0, gdi_pkg::BUF_OFS, 32'h0, q);
    check_word(q, 32'h0000A5C3, "buffer read");
    $display("test buffer done");
  endtask : t_buffer
  task automatic t_input(input logic [15:0] v);
    logic [31:0] q;
    int n;
    input_lines <= v;
    repeat (4) @(posedge hclk);
    ahb_xfer(1'b0, gdi_pkg::INP_OFS, 32'h0, q);
    check_word(q, {16'h0000, v}, "input lines");
    check_word({31'h0, input_read}, 32'h1, "read pulse");
    wait_for(7, 1'b0, 60, n);
    check_word(32'(n), gdi_pkg::PULSE_CYC, "read pulse width");
    $display("test input done");
  endtask : t_input
  task automatic t_flags();
    logic [31:0] q;
    user_in[0].flag <= 1'b1;
    repeat (8) @(posedge hclk);
    ahb_xfer(1'b0, gdi_pkg::CSR_OFS, 32'h0, q);
    check_word(q, 32'h00000080, "flag a");
    check_word({28'h0, bus_out.bus_request_line}, 32'h0, "masked flag");
    user_in[0].flag <= 1'b0;
    user_in[1].flag <= 1'b1;
    repeat (8) @(posedge hclk);
    ahb_xfer(1'b0, gdi_pkg::CSR_OFS, 32'h0, q);
    check_word(q, 32'h00008000, "flag b");
    user_in[1].flag <= 1'b0;
    ahb_xfer(1'b1, gdi_pkg::CSR_OFS, 32'h0000FFFF, q);
    ahb_xfer(1'b0, gdi_pkg::CSR_OFS, 32'h0, q);
    check_word(q, 32'h00000060, "enables set");
    ahb_xfer(1'b1, gdi_pkg::CSR_OFS, 32'h0, q);
    ahb_xfer(1'b0, gdi_pkg::CSR_OFS, 32'h0, q);
    check_word(q, 32'h00000000, "enables clear");
    $display("test flags done");
  endtask : t_flags
  task automatic t_master(input int ch, input logic sl, input logic hold);
    logic [31:0] q;
    int n;
    slow <= sl;
    other_busy <= hold;
    ahb_xfer(1'b1, gdi_pkg::CFG_OFS, 32'h00000100 << ch, q);
    ahb_xfer(1'b1, gdi_pkg::CSR_OFS, 32'h00000040 >> ch, q);
    user_in[ch].flag <= 1'b1;
    wait_for(8, 1'b1, 20, n);
    check_word({28'h0, bus_out.bus_request_line}, 32'h2 << ch, "request level");
    wait_for(5, 1'b1, 40, n);
    check_word({31'h0, bus_out.bus_grant_out}, 32'h0, "grant held");
    repeat (10) @(posedge hclk);
    check_word({31'h0, user_out[ch].owner}, {31'h0, !hold}, "owner vs busy");
    other_busy <= 1'b0;
    wait_for(ch, 1'b1, 20, n);
    check_word({31'h0, bus_out.bus_busy_o}, 32'h1, "busy driven");
    user_in[ch].release_req <= 1'b1;
    wait_for(ch, 1'b0, 20, n);
    user_in[ch].release_req <= 1'b0;
    repeat (12) @(posedge hclk);
    check_word({28'h0, bus_out.bus_request_line}, 32'h0, "no new request");
    user_in[ch].flag <= 1'b0;
    repeat (6) @(posedge hclk);
    user_in[ch].flag <= 1'b1;
    wait_for(ch, 1'b1, 60, n);
    ahb_xfer(1'b1, gdi_pkg::CSR_OFS, 32'h0, q);
    wait_for(ch, 1'b0, 20, n);
    user_in[ch].flag <= 1'b0;
    $display("test master %0d done", ch);
  endtask : t_master
  task automatic t_vector(input int ch, input logic vls, input logic [5:0] jmp);
    logic [31:0] q;
    int n;
    ahb_xfer(1'b1, gdi_pkg::CFG_OFS, {22'h0, 2'h1, 2'h0, jmp}, q);
    vector_low_select <= vls;
    user_in[ch].vector_start <= 1'b1;
    wait_for(2, 1'b1, 20, n);
    check_word({23'h0, bus_out.data_o[8:0]}, {23'h0, ~jmp, vls, 2'h0}, "vec");
    wait_for(3 + ch, 1'b1, 40, n);
    check_word({31'h0, bus_out.interrupt_vector_strobe_o}, 32'h0, "strobe off");
    user_in[ch].vector_start <= 1'b0;
    wait_for(3 + ch, 1'b0, 20, n);
    $display("test vector %0d done", ch);
  endtask : t_vector
  // ==========================================================================
  // main sequence
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    user_in = '0;
    vector_low_select = 1'b0;
    input_lines = 16'h0000;
    slow = 1'b0;
    other_busy = 1'b0;
    errors = 0;
    n_tests = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_buffer();
    t_input(16'h5A3C);
    t_input(16'hA5C3);
    t_flags();
    t_master(0, 1'b0, 1'b1);
    t_master(1, 1'b1, 1'b0);
    t_vector(0, 1'b1, 6'h15);
    t_vector(1, 1'b0, 6'h2A);
    t_vector(0, 1'b0, 6'h3F);
    t_vector(1, 1'b1, 6'h00);
    finish_test();
  end
endmodule : tb_gdi_top
